//--- design/kwdt_pkg.sv
// constants shared by the keyed watchdog timer
package kwdt_pkg;
  localparam int unsigned SYS_CLK_HZ   = 100_000_000;
  localparam int unsigned LOW_SPEED_RC_OSCILLATOR_HZ      = 32_000;
  localparam int unsigned LOW_SPEED_RC_OSCILLATOR_DIV     = SYS_CLK_HZ / LOW_SPEED_RC_OSCILLATOR_HZ;
  localparam int unsigned KEY_TICKS    = 2;
  localparam int unsigned MIN_SHIFT    = 8;
  localparam int unsigned CNT_W        = 16;

  // register byte offsets
  localparam logic [7:0] OFS_WDT_CTRL  = 8'h00;
  localparam logic [7:0] OFS_MODE_ONE  = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_INT_STAT  = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK  = 8'h10;
  localparam logic [7:0] OFS_COUNT     = 8'h14;

  // watchdog_control layout and reset
  localparam logic [7:0] WDT_CTRL_POR  = 8'h53;
  localparam int unsigned KEY_LSB      = 3;
  localparam logic [4:0] KEY_ENABLE    = 5'h0a;
  localparam logic [4:0] KEY_DISABLE   = 5'h15;

  // mode_control_one bit positions
  localparam int unsigned M1_SYSCLK    = 7;
  localparam int unsigned M1_PINCFG    = 3;
  localparam int unsigned M1_LOWV      = 2;
  localparam int unsigned M1_KEYRST    = 0;

  // interrupt bit positions
  localparam int unsigned IRQ_TIMEOUT  = 0;
  localparam int unsigned IRQ_KEYRST   = 1;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

//--- design/kwdt_pin_sync.sv
// three-stage pin synchroniser that changes once stages two and three agree
`timescale 1ns/1ps
module kwdt_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] stage;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      stage <= {3{RESET_LEVEL}};
      level <= RESET_LEVEL;
    end
    else
    begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2])
      begin
        level <= stage[2];
      end
    end
  end
endmodule

//--- design/kwdt_top.sv
// keyed watchdog timer with axi4-lite register access
// How it works
// - counter advances by one on every low-speed oscillator tick, with no prescaler
// - timeout select codes 0 to 7 give 2^8 to 2^15 oscillator periods
// - key 01010 enables the watchdog, key 10101 disables it
// - any other key resets the device after two to three oscillator cycles
// - key reset sets the key-reset flag; only software write clears it
// - overflow in normal operation gives full reset and sets timeout flag
// - overflow while sleeping or idle sets timeout flag, resets only pc and sp
// - counter cleared by bad key, reset pin low, clear instruction or halt
// - unimplemented mode register bits 6 to 4 and 1 read as zero
// - halt with watchdog enabled clears it and counting resumes
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module kwdt_top
  import kwdt_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = kwdt_pkg::LOW_SPEED_RC_OSCILLATOR_DIV
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        reset_pin_n,
  input  wire logic        clear_watchdog_instruction,
  input  wire logic        halt_instr,
  input  wire logic        sleep_idle,
  output logic             device_reset,
  output logic             pc_sp_reset,
  output logic             irq,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  import kwdt_pkg::*;

  logic [7:0]       watchdog_control;
  logic             idle_sysclk_keep;
  logic             pin_config_reset_flag;
  logic             low_voltage_reset_flag;
  logic             key_reset_flag;
  logic             timeout_status_flag;
  logic [1:0]       int_status;
  logic [1:0]       int_mask;
  logic [CNT_W-1:0] count;
  logic [31:0]      div_cnt;
  logic             low_speed_rc_oscillator_tick;
  logic [1:0]       key_ticks;
  logic             pin_level;
  logic [7:0]       aw_addr;
  logic             aw_held;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             w_held;

  logic [4:0] key;
  logic       wdt_enabled;
  logic       key_bad;
  logic       key_fire;
  logic       overflow;
  logic       clear_cnt;
  logic       wr_fire;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_istat;
  logic       wr_imask;
  logic       wr_known;

  function automatic logic [CNT_W-1:0] overflow_limit(input logic [2:0] sel);
    logic [CNT_W-1:0] one;
    one = {{(CNT_W-1){1'b0}}, 1'b1};
    overflow_limit = (one << (MIN_SHIFT + 32'(sel))) - one;
  endfunction

  assign key         = watchdog_control[7:KEY_LSB];
  assign wdt_enabled = (key == KEY_ENABLE);
  assign key_bad     = (key != KEY_ENABLE) && (key != KEY_DISABLE);
  // fires on the third tick after the key went bad, two to three oscillator periods later
  assign key_fire    = key_bad && low_speed_rc_oscillator_tick && (key_ticks == 2'(KEY_TICKS));
  // at or past the limit, so a smaller select written mid-count still ends the period
  assign overflow    = wdt_enabled && low_speed_rc_oscillator_tick
                       && (count >= overflow_limit(watchdog_control[2:0]));
  assign clear_cnt   = key_bad || !pin_level || clear_watchdog_instruction || halt_instr;

  assign wr_fire  = aw_held && w_held && !s_bvalid;
  assign wr_ctrl  = wr_fire && w_strb[0] && (aw_addr == OFS_WDT_CTRL);
  assign wr_mode  = wr_fire && w_strb[0] && (aw_addr == OFS_MODE_ONE);
  assign wr_istat = wr_fire && w_strb[0] && (aw_addr == OFS_INT_STAT);
  assign wr_imask = wr_fire && w_strb[0] && (aw_addr == OFS_INT_MASK);
  assign wr_known = (aw_addr == OFS_WDT_CTRL) || (aw_addr == OFS_MODE_ONE) || (aw_addr == OFS_STATUS)
                    || (aw_addr == OFS_INT_STAT) || (aw_addr == OFS_INT_MASK) || (aw_addr == OFS_COUNT);

  kwdt_pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin     (reset_pin_n),
    .level   (pin_level)
  );

  // low-speed oscillator tick from the system clock
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt   <= 32'h0;
      low_speed_rc_oscillator_tick <= 1'b0;
    end
    else if (div_cnt == DIV_CYCLES - 1)
    begin
      div_cnt   <= 32'h0;
      low_speed_rc_oscillator_tick <= 1'b1;
    end
    else
    begin
      div_cnt   <= div_cnt + 32'h1;
      low_speed_rc_oscillator_tick <= 1'b0;
    end
  end

  // watchdog count, restarts from zero on every clear and on overflow
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
    end
    else if (clear_cnt || overflow)
    begin
      count <= '0;
    end
    else if (wdt_enabled && low_speed_rc_oscillator_tick)
    begin
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // debounce of a bad key over oscillator ticks
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      key_ticks <= 2'h0;
    end
    else if (!key_bad || key_fire)
    begin
      key_ticks <= 2'h0;
    end
    else if (low_speed_rc_oscillator_tick)
    begin
      key_ticks <= key_ticks + 2'h1;
    end
  end

  // reset outputs
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      device_reset <= 1'b0;
      pc_sp_reset  <= 1'b0;
    end
    else
    begin
      device_reset <= key_fire || (overflow && !sleep_idle);
      pc_sp_reset  <= overflow && sleep_idle && !key_fire;
    end
  end

  // watchdog_control, restored to its reset value by a key reset
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      watchdog_control <= WDT_CTRL_POR;
    end
    else if (key_fire)
    begin
      watchdog_control <= WDT_CTRL_POR;
    end
    else if (wr_ctrl)
    begin
      watchdog_control <= w_data[7:0];
    end
  end

  // mode_control_one: key_reset_flag is set by a key reset; the flags are cleared only by writing zero
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      idle_sysclk_keep       <= 1'b0;
      pin_config_reset_flag  <= 1'b0;
      low_voltage_reset_flag <= 1'b0;
      key_reset_flag         <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        idle_sysclk_keep <= w_data[M1_SYSCLK];
        if (!w_data[M1_PINCFG])
        begin
          pin_config_reset_flag <= 1'b0;
        end
        if (!w_data[M1_LOWV])
        begin
          low_voltage_reset_flag <= 1'b0;
        end
      end
      if (key_fire)
      begin
        key_reset_flag <= 1'b1;
      end
      else if (wr_mode && !w_data[M1_KEYRST])
      begin
        key_reset_flag <= 1'b0;
      end
    end
  end

  // timeout flag, cleared by clear instruction or halt unless set again
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      timeout_status_flag <= 1'b0;
    end
    else if (overflow)
    begin
      timeout_status_flag <= 1'b1;
    end
    else if (clear_watchdog_instruction || halt_instr)
    begin
      timeout_status_flag <= 1'b0;
    end
  end

  // interrupt status (write one to clear, set wins) and mask
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      int_status <= 2'h0;
      int_mask   <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      int_status[IRQ_TIMEOUT] <= overflow
                                 || (int_status[IRQ_TIMEOUT] && !(wr_istat && w_data[IRQ_TIMEOUT]));
      int_status[IRQ_KEYRST]  <= key_fire
                                 || (int_status[IRQ_KEYRST] && !(wr_istat && w_data[IRQ_KEYRST]));
      if (wr_imask)
      begin
        int_mask <= w_data[1:0];
      end
      irq <= |(int_status & int_mask);
    end
  end

  // axi4-lite write channel
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 8'h0;
      w_data    <= 32'h0;
      w_strb    <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_addr   <= {s_awaddr[7:2], 2'b00};
        aw_held   <= 1'b1;
        s_awready <= 1'b0;
      end
      else if (!aw_held && !s_bvalid)
      begin
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready)
      begin
        w_data   <= s_wdata;
        w_strb   <= s_wstrb;
        w_held   <= 1'b1;
        s_wready <= 1'b0;
      end
      else if (!w_held && !s_bvalid)
      begin
        s_wready <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel, data one cycle after the address is taken
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= RESP_OKAY;
      if (s_araddr[7:2] == OFS_WDT_CTRL[7:2])
      begin
        s_rdata <= {24'h0, watchdog_control};
      end
      else if (s_araddr[7:2] == OFS_MODE_ONE[7:2])
      begin
        s_rdata <= {24'h0, idle_sysclk_keep, 3'b000, pin_config_reset_flag,
                    low_voltage_reset_flag, 1'b0, key_reset_flag};
      end
      else if (s_araddr[7:2] == OFS_STATUS[7:2])
      begin
        s_rdata <= {29'h0, key_bad, wdt_enabled, timeout_status_flag};
      end
      else if (s_araddr[7:2] == OFS_INT_STAT[7:2])
      begin
        s_rdata <= {30'h0, int_status};
      end
      else if (s_araddr[7:2] == OFS_INT_MASK[7:2])
      begin
        s_rdata <= {30'h0, int_mask};
      end
      else if (s_araddr[7:2] == OFS_COUNT[7:2])
      begin
        s_rdata <= {{(32-CNT_W){1'b0}}, count};
      end
      else
      begin
        s_rdata <= 32'h0;
        s_rresp <= RESP_SLVERR;
      end
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
    end
    else if (!s_rvalid)
    begin
      s_arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  tick_period_a: assert property (low_speed_rc_oscillator_tick |=> !low_speed_rc_oscillator_tick)
    else $error("oscillator tick lasted more than one cycle");
  overflow_count_a: assert property (wdt_enabled && low_speed_rc_oscillator_tick && !clear_cnt
                                     && count >= overflow_limit(watchdog_control[2:0])
                                     |=> count == '0 && timeout_status_flag)
    else $error("overflow did not restart the count");
  disable_stops_a: assert property (key == KEY_DISABLE |=> count == '0 || $stable(count))
    else $error("disabled watchdog counted");
  key_reset_a: assert property (key_fire |=> device_reset && key_reset_flag)
    else $error("bad key did not reset");
  flag_sticky_a: assert property ($fell(key_reset_flag) |-> $past(wr_mode))
    else $error("key reset flag cleared without write");
  full_reset_a: assert property (overflow && !sleep_idle |=> device_reset && timeout_status_flag)
    else $error("normal overflow missed full reset");
  sleep_reset_a: assert property (overflow && sleep_idle && !key_fire
                                  |=> pc_sp_reset && !device_reset && timeout_status_flag)
    else $error("sleep overflow wrong reset");
  clear_count_a: assert property (clear_cnt |=> count == '0)
    else $error("clear did not zero count");
  mode_zero_a: assert property (s_rvalid && $past(s_arvalid && s_arready && s_araddr[7:2] == OFS_MODE_ONE[7:2])
                                |-> s_rdata[6:4] == 3'h0 && s_rdata[1] == 1'b0)
    else $error("unimplemented mode bits not zero");

  cover_sleep_c: cover property (pc_sp_reset);
  cover_full_c: cover property (overflow && !sleep_idle);
  cover_key_c: cover property (key_fire);
  cover_irq_c: cover property (irq);
endmodule

//--- sim/kwdt_cpu_model.sv
// cpu core stand-in issuing clear and halt instructions
`timescale 1ns/1ps
module kwdt_cpu_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        kick_en,
  input  wire logic [15:0] kick_gap,
  input  wire logic        clear_req,
  input  wire logic        halt_req,
  input  wire logic        wake,
  output logic             clear_watchdog_instruction,
  output logic             halt_instr,
  output logic             sleep_idle
);
  logic [15:0] gap_cnt;

  // program loop clearing the watchdog every kick_gap+1 cycles
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      gap_cnt <= 16'h0;
      clear_watchdog_instruction <= 1'b0;
    end
    else
    begin
      gap_cnt <= (kick_en && gap_cnt < kick_gap) ? gap_cnt + 16'h1 : 16'h0;
      clear_watchdog_instruction <= clear_req || (kick_en && gap_cnt == kick_gap);
    end
  end

  // halt puts the core to sleep until a watchdog wake
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      halt_instr <= 1'b0;
      sleep_idle <= 1'b0;
    end
    else
    begin
      halt_instr <= halt_req;
      if (halt_req)
        sleep_idle <= 1'b1;
      else if (wake)
        sleep_idle <= 1'b0;
    end
  end
endmodule

//--- sim/tb.sv
// self-checking bench for the keyed watchdog timer
`timescale 1ns/1ps
module tb;
  import kwdt_pkg::*;
  localparam int DIV = 4;
  typedef struct {logic [33:0] v; int t;} kwdt_exp_t;
  logic        sys_clk, reset, reset_pin_n, clear_watchdog_instruction, halt_instr, sleep_idle;
  logic        device_reset, pc_sp_reset, irq, kick_en, clear_req, halt_req, m7;
  logic [15:0] gap;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, cyc;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [33:0] rq[$];
  kwdt_exp_t   eq[$];
  int          fails, tests_run, seed;

  kwdt_top #(.DIV_CYCLES(DIV)) uut (.sys_clk, .reset, .reset_pin_n, .clear_watchdog_instruction,
    .halt_instr, .sleep_idle, .device_reset, .pc_sp_reset, .irq, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  kwdt_cpu_model cpu (.sys_clk, .reset, .kick_en, .kick_gap(gap), .clear_req, .halt_req,
    .wake(device_reset || pc_sp_reset), .clear_watchdog_instruction, .halt_instr, .sleep_idle);

  always #5 sys_clk = ~sys_clk;

  task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] s);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bus_res(input logic [33:0] s);
    logic [33:0] e;
    e = 'x;
    if (rq.size() > 0)
      e = rq.pop_front();
    cmp("bus answer", e, s);
  endtask

  // a reset pulse matches when its kind agrees and it lands within the tolerance
  task automatic evt_res(input logic [33:0] s);
    kwdt_exp_t x;
    x = '{'x, 0};
    if (eq.size() > 0)
      x = eq.pop_front();
    if (s[33:32] === x.v[33:32] && s[31:0] + x.t >= x.v[31:0] && s[31:0] <= x.v[31:0] + x.t)
      s = x.v;
    cmp("reset pulse", x.v, s);
  endtask

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 32'h1;
    if (s_rvalid && s_rready)
      bus_res({s_rresp, s_rdata});
    if (s_bvalid && s_bready)
      bus_res({s_bresp, 32'h0});
    if (device_reset || pc_sp_reset)
      evt_res({pc_sp_reset, device_reset, cyc});
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic b;
    rq.push_back({r, 32'h0});
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    b = 1'b1;
    while (b)
    begin
      @(posedge sys_clk);
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
      if (s_bvalid)
        b = 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic b;
    rq.push_back(e);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    b = 1'b1;
    while (b)
    begin
      @(posedge sys_clk);
      if (s_arready)
        s_arvalid <= 1'b0;
      if (s_rvalid)
        b = 1'b0;
    end
  endtask

  function automatic logic [31:0] ctl(input logic [4:0] k, input logic [2:0] s);
    return {24'h0, k, s};
  endfunction

  // one-cycle request to the cpu stand-in: 0 clear instruction, 1 halt
  task automatic pulse(input logic h);
    if (h)
      halt_req <= 1'b1;
    else
      clear_req <= 1'b1;
    @(posedge sys_clk);
    if (h)
      halt_req <= 1'b0;
    else
      clear_req <= 1'b0;
  endtask

  // expected pulse kind and its distance in cycles from now
  task automatic ex(input logic [1:0] k, input int d, input int t);
    eq.push_back('{{k, cyc + 32'(d)}, t});
  endtask

  task automatic wait_evt();
    while (eq.size() > 0)
      @(posedge sys_clk);
    // let the registered irq settle after the pulse
    @(posedge sys_clk);
  endtask

  task automatic arm(input logic [2:0] s);
    wr(OFS_WDT_CTRL, ctl(KEY_ENABLE, s), RESP_OKAY);
    pulse(1'b0);
  endtask

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    stop_test();
  end

  initial
  begin
    {sys_clk, reset_pin_n, kick_en, clear_req, halt_req, s_awaddr, s_araddr, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_arvalid, cyc, fails, tests_run} = '0;
    {s_bready, s_rready} = 2'b11;
    s_wstrb = 4'hf;
    reset = 1'b1;
    reset_pin_n = 1'b1;
    seed = 78;
    gap = 16'h0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wr(OFS_WDT_CTRL, ctl(KEY_DISABLE, 3'h0), RESP_OKAY);
    rd(OFS_STATUS, 34'h0);
    rd(OFS_MODE_ONE, 34'h0);
    rd(OFS_INT_MASK, 34'h0);
    m7 = 1'($random(seed));
    wr(OFS_MODE_ONE, {24'h0, m7, 7'h7f}, RESP_OKAY);
    rd(OFS_MODE_ONE, {RESP_OKAY, 24'h0, m7, 7'h0});
    wr(8'h18, 32'h1, RESP_SLVERR);
    rd(8'h18, {RESP_SLVERR, 32'h0});
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_WDT_CTRL, ctl(KEY_DISABLE, 3'(i)), RESP_OKAY);
      rd(OFS_WDT_CTRL, {RESP_OKAY, ctl(KEY_DISABLE, 3'(i))});
    end
    pulse(1'b0);
    rd(OFS_COUNT, 34'h0);
    wr(OFS_INT_MASK, 32'h3, RESP_OKAY);
    arm(3'h0);
    ex(2'b01, 256 * DIV + 2, 4);
    wait_evt();
    cmp("irq", 34'h1, {33'h0, irq});
    wr(OFS_WDT_CTRL, ctl(KEY_DISABLE, 3'h0), RESP_OKAY);
    rd(OFS_STATUS, {RESP_OKAY, 32'h1});
    rd(OFS_INT_STAT, {RESP_OKAY, 32'h1});
    wr(OFS_INT_STAT, 32'h1, RESP_OKAY);
    rd(OFS_INT_STAT, 34'h0);
    cmp("irq", 34'h0, {33'h0, irq});
    arm(3'h1);
    repeat (500) @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    ex(2'b01, 512 * DIV + 6, 6);
    wait_evt();
    wr(OFS_WDT_CTRL, ctl(KEY_DISABLE, 3'h0), RESP_OKAY);
    arm(3'h0);
    pulse(1'b1);
    ex(2'b10, 256 * DIV + 3, 4);
    wait_evt();
    wr(OFS_WDT_CTRL, ctl(KEY_DISABLE, 3'h0), RESP_OKAY);
    rd(OFS_STATUS, {RESP_OKAY, 32'h1});
    pulse(1'b0);
    @(posedge sys_clk);
    rd(OFS_STATUS, 34'h0);
    wr(OFS_INT_STAT, 32'h3, RESP_OKAY);
    arm(3'h0);
    gap <= 16'(300 + ($random(seed) & 255));
    kick_en <= 1'b1;
    repeat (4000) @(posedge sys_clk);
    kick_en <= 1'b0;
    wr(OFS_WDT_CTRL, ctl(KEY_DISABLE, 3'h0), RESP_OKAY);
    // count is frozen mid-period here, so the clear must zero it
    pulse(1'b0);
    @(posedge sys_clk);
    rd(OFS_COUNT, 34'h0);
    wr(OFS_WDT_CTRL, 32'h0, RESP_OKAY);
    ex(2'b01, 11, 2);
    wait_evt();
    rd(OFS_WDT_CTRL, {RESP_OKAY, 24'h0, WDT_CTRL_POR});
    wr(OFS_WDT_CTRL, ctl(KEY_DISABLE, 3'h0), RESP_OKAY);
    rd(OFS_MODE_ONE, {RESP_OKAY, 24'h0, m7, 7'h01});
    rd(OFS_INT_STAT, {RESP_OKAY, 32'h2});
    cmp("irq", 34'h1, {33'h0, irq});
    wr(OFS_MODE_ONE, {24'h0, m7, 7'h01}, RESP_OKAY);
    rd(OFS_MODE_ONE, {RESP_OKAY, 24'h0, m7, 7'h01});
    wr(OFS_MODE_ONE, {24'h0, m7, 7'h00}, RESP_OKAY);
    rd(OFS_MODE_ONE, {RESP_OKAY, 24'h0, m7, 7'h00});
    wr(OFS_INT_STAT, 32'h3, RESP_OKAY);
    @(posedge sys_clk);
    cmp("irq", 34'h0, {33'h0, irq});
    repeat (20) @(posedge sys_clk);
    cmp("pending", 34'h0, 34'(rq.size() + eq.size()));
    stop_test();
  end
endmodule
